// File: rtl/rsd_defs.vh
`ifndef RSD_DEFS_VH
`define RSD_DEFS_VH
// APB register byte offsets
`define RSD_CTRL_OFF 12'h000
`define RSD_SWITCH_OFF 12'h004
`define RSD_TGT_IN_OFF 12'h008
`define RSD_PAT_IN_OFF 12'h00c
`define RSD_STATUS_OFF 12'h010
`define RSD_DISP_OFF 12'h014
`define RSD_PRINT_OFF 12'h018
// Control register fields
`define RSD_CTRL_MOVING 0
`define RSD_CTRL_OPP_CLASS 1
`define RSD_CTRL_MOV_CLASS 2
// Switch event register bits (write one to press)
`define RSD_SW_LOCK 0
`define RSD_SW_STANDBY 1
`define RSD_SW_TEST 2
`define RSD_SW_ON 3
`define RSD_SW_OFF 4
`define RSD_SW_MODE 5
`define RSD_SW_PRINT 6
`define RSD_SW_TEST_END 7
// Speed input fields
`define RSD_SPD_W 8
`define RSD_IN_VALID 8
// Status fields
`define RSD_ST_LOCKED 0
`define RSD_ST_SELFTEST 1
`define RSD_ST_STANDBY 2
`define RSD_ST_TGT_BLANK 3
`define RSD_ST_PAT_BLANK 4
`define RSD_ST_REMOTE 5
// Speed limits in mph and control reset value
`define RSD_CLOSING_MAX 9'h0d2
`define RSD_PATROL_LIM 8'h37
`define RSD_CTRL_RST 3'h6
`endif

// File: rtl/rsd_sync2.v
`timescale 1ns/10ps
// Two-flop synchroniser for a pin level
module rsd_sync2 (
  input wire i_clk,
  input wire i_srst,
  input wire i_d,
  output wire o_q
);
  reg s1_reg;
  reg s2_reg;

  // Only the second stage is read outside
  always @(posedge i_clk) begin
    if (i_srst) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
    end else begin
      s1_reg <= i_d;
      s2_reg <= s1_reg;
    end
  end
  assign o_q = s2_reg;
endmodule // rsd_sync2

// File: rtl/rsd_disp_hold.v
`timescale 1ns/10ps
// One speed display channel: follow, lock, blank
module rsd_disp_hold (
  input wire i_clk,
  input wire i_srst,
  input wire i_clear,
  input wire i_lock,
  input wire i_unlock,
  input wire i_valid,
  input wire [7:0] i_speed,
  output reg [7:0] o_speed,
  output reg o_blank,
  output reg o_locked
);
  // Locked value never follows the input; unlocked value blanks on loss
  always @(posedge i_clk) begin
    if (i_srst || i_clear) begin
      o_speed <= 8'h00;
      o_blank <= 1'b1;
      o_locked <= 1'b0;
    end else if (i_unlock) begin
      o_locked <= 1'b0;
    end else if (o_locked) begin
      o_locked <= 1'b1;
    end else if (i_lock) begin
      o_locked <= ~o_blank;
    end else if (i_valid) begin
      o_speed <= i_speed;
      o_blank <= 1'b0;
    end else begin
      o_blank <= 1'b1;
      o_speed <= 8'h00;
    end
  end
endmodule // rsd_disp_hold

// File: rtl/rsd_top.v
`timescale 1ns/10ps
`include "rsd_defs.vh"
// Functional notes
// - Locking happens only when the operator presses the lock switch.
// - A locked reading keeps its value despite target change or loss.
// - Unlocked target display blanks once the target signal is lost.
// - Lock pressed on a blank display keeps it blank.
// - Lock, hold and blank apply to target and patrol each on its own; patrol locks only in moving mode.
// - Any switch but lock, print or test-end discards unlocked readings while neither channel is locked, either mode.
// - Only the on, off or mode switch discards a locked reading.
// - Self-check shows only check values and clears them when done.
// - Lock ignored during self-check; check values never held afterwards.
// - Target present on leaving off or standby is acquired and shown.
// - Moving mode shows 100 mph target with 55 mph patrol.
// - Opposing class suppresses target at closing 210 mph, patrol at most 55.
// - Patrol channel shows patrol speeds across the required range.
// - Patrol display tracks rising patrol speed cycle by cycle.
// - Patrol display tracks falling patrol speed cycle by cycle.
// - Remote display or printer mirrors lock and clear of main displays.
// - Remote display is cleared on reconnection.
// - Print with reading locked emits a record of the locked reading.
module rsd_top (
  input wire i_clk,
  input wire i_srst,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [11:0] i_paddr,
  input wire [31:0] i_pwdata,
  output reg [31:0] o_prdata,
  output reg o_pready,
  output reg o_pslverr,
  input wire i_remote_present,
  output reg [7:0] o_tgt_speed,
  output reg o_tgt_blank,
  output reg [7:0] o_pat_speed,
  output reg o_pat_blank,
  output reg o_locked,
  output reg [7:0] o_rem_tgt,
  output reg [7:0] o_rem_pat,
  output reg o_rem_blank,
  output reg o_print_stb,
  output reg [23:0] o_print_rec
);
  reg [2:0] ctrl_reg;
  reg [7:0] tgt_in_reg;
  reg tgt_vld_reg;
  reg [7:0] pat_in_reg;
  reg pat_vld_reg;
  reg standby_reg;
  reg selftest_reg;
  reg [7:0] sw_reg;
  reg rem_prev_reg;
  reg [7:0] test_val_reg;
  wire rem_sync;
  wire wr_en;
  wire rd_en;
  wire [7:0] sw;
  wire sw_other;
  wire clear_unlocked;
  wire clear_locked;
  wire lock_req;
  wire tgt_ok;
  wire pat_ok;
  wire [8:0] closing;
  wire t_lock_cmd;
  wire p_lock_cmd;
  wire [7:0] t_speed;
  wire [7:0] p_speed;
  wire t_blank;
  wire p_blank;
  wire t_locked;
  wire p_locked;
  wire any_locked;
  wire rem_connect;

  rsd_sync2 u_rem_sync (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_d(i_remote_present),
    .o_q(rem_sync)
  );

  assign wr_en = i_psel & i_penable & i_pwrite;
  assign rd_en = i_psel & ~i_penable & ~i_pwrite;
  // Switch presses arrive as one-cycle write pulses
  assign sw = (wr_en && i_paddr == `RSD_SWITCH_OFF) ? i_pwdata[7:0] : 8'h00;
  assign sw_other = |(sw & ~(8'h01 << `RSD_SW_LOCK) & ~(8'h01 << `RSD_SW_TEST_END)
                      & ~(8'h01 << `RSD_SW_PRINT));
  assign any_locked = t_locked | p_locked;
  // Switches other than lock, print and test-end clear unlocked readings while no channel is locked
  assign clear_unlocked = sw_other & ~any_locked;
  // Standby and test keep a locked reading
  assign clear_locked = any_locked & |(sw & ((8'h01 << `RSD_SW_ON) | (8'h01 << `RSD_SW_OFF)
                        | (8'h01 << `RSD_SW_MODE)));
  // Lock only from the operator switch, never during self-check
  assign lock_req = sw[`RSD_SW_LOCK] & ~selftest_reg & ~standby_reg;
  assign t_lock_cmd = lock_req;
  assign p_lock_cmd = lock_req & ctrl_reg[`RSD_CTRL_MOVING];
  // Closing speed limit for opposing-traffic class
  assign closing = {1'b0, tgt_in_reg} + {1'b0, pat_in_reg};
  assign tgt_ok = tgt_vld_reg & ~standby_reg & ~selftest_reg
                  & ~(ctrl_reg[`RSD_CTRL_OPP_CLASS] & ctrl_reg[`RSD_CTRL_MOVING]
                  & (closing >= `RSD_CLOSING_MAX)
                  & (pat_in_reg <= `RSD_PATROL_LIM));
  assign pat_ok = pat_vld_reg & ctrl_reg[`RSD_CTRL_MOVING] & ~standby_reg
                  & ~selftest_reg;
  assign rem_connect = rem_sync & ~rem_prev_reg;

  // Separate channel instances keep target and patrol values apart
  rsd_disp_hold u_tgt (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_clear(clear_unlocked | clear_locked),
    .i_lock(t_lock_cmd),
    .i_unlock(1'b0),
    .i_valid(tgt_ok),
    .i_speed(tgt_in_reg),
    .o_speed(t_speed),
    .o_blank(t_blank),
    .o_locked(t_locked)
  );

  rsd_disp_hold u_pat (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_clear(clear_unlocked | clear_locked),
    .i_lock(p_lock_cmd),
    .i_unlock(1'b0),
    .i_valid(pat_ok),
    .i_speed(pat_in_reg),
    .o_speed(p_speed),
    .o_blank(p_blank),
    .o_locked(p_locked)
  );

  // Register writes and mode state
  always @(posedge i_clk) begin
    if (i_srst) begin
      ctrl_reg <= `RSD_CTRL_RST;
      tgt_in_reg <= 8'h00;
      tgt_vld_reg <= 1'b0;
      pat_in_reg <= 8'h00;
      pat_vld_reg <= 1'b0;
      standby_reg <= 1'b1;
      selftest_reg <= 1'b0;
      test_val_reg <= 8'h00;
      rem_prev_reg <= 1'b0;
    end else begin
      rem_prev_reg <= rem_sync;
      if (wr_en && i_paddr == `RSD_CTRL_OFF) begin
        ctrl_reg <= i_pwdata[2:0];
      end else if (wr_en && i_paddr == `RSD_TGT_IN_OFF) begin
        tgt_in_reg <= i_pwdata[7:0];
        tgt_vld_reg <= i_pwdata[`RSD_IN_VALID];
      end else if (wr_en && i_paddr == `RSD_PAT_IN_OFF) begin
        pat_in_reg <= i_pwdata[7:0];
        pat_vld_reg <= i_pwdata[`RSD_IN_VALID];
      end
      if (sw[`RSD_SW_STANDBY] || sw[`RSD_SW_OFF]) begin
        standby_reg <= 1'b1;
      end else if (sw[`RSD_SW_ON] || sw[`RSD_SW_MODE]) begin
        standby_reg <= 1'b0;
      end
      if (sw[`RSD_SW_TEST]) begin
        selftest_reg <= 1'b1;
        test_val_reg <= 8'h88;
      end else if (sw[`RSD_SW_TEST_END]) begin
        selftest_reg <= 1'b0;
        test_val_reg <= 8'h00;
      end
    end
  end

  // Display outputs: check values override readings during self-check
  always @(posedge i_clk) begin
    if (i_srst) begin
      o_tgt_speed <= 8'h00;
      o_tgt_blank <= 1'b1;
      o_pat_speed <= 8'h00;
      o_pat_blank <= 1'b1;
      o_locked <= 1'b0;
    end else if (selftest_reg) begin
      o_tgt_speed <= test_val_reg;
      o_tgt_blank <= 1'b0;
      o_pat_speed <= test_val_reg;
      o_pat_blank <= 1'b0;
      o_locked <= 1'b0;
    end else begin
      o_tgt_speed <= t_speed;
      o_tgt_blank <= t_blank;
      o_pat_speed <= p_speed;
      o_pat_blank <= p_blank;
      o_locked <= any_locked;
    end
  end

  // Remote display mirrors main, cleared on reconnect
  always @(posedge i_clk) begin
    if (i_srst) begin
      o_rem_tgt <= 8'h00;
      o_rem_pat <= 8'h00;
      o_rem_blank <= 1'b1;
    end else if (rem_connect || !rem_sync) begin
      o_rem_tgt <= 8'h00;
      o_rem_pat <= 8'h00;
      o_rem_blank <= 1'b1;
    end else begin
      o_rem_tgt <= o_tgt_speed;
      o_rem_pat <= o_pat_speed;
      o_rem_blank <= o_tgt_blank;
    end
  end

  // Print record of locked reading
  always @(posedge i_clk) begin
    if (i_srst) begin
      o_print_stb <= 1'b0;
      o_print_rec <= 24'h000000;
    end else if (sw[`RSD_SW_PRINT] && any_locked && !selftest_reg) begin
      o_print_stb <= 1'b1;
      o_print_rec <= {ctrl_reg[1:0], 6'h00, t_speed, p_speed};
    end else begin
      o_print_stb <= 1'b0;
    end
  end

  // APB slave: zero wait states, error on unmapped address
  always @(posedge i_clk) begin
    if (i_srst) begin
      o_prdata <= 32'h00000000;
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready <= i_psel & ~i_penable;
      o_pslverr <= 1'b0;
      if (i_psel && !i_penable) begin
        if (i_paddr == `RSD_CTRL_OFF) begin
          o_prdata <= {29'h0, ctrl_reg};
        end else if (i_paddr == `RSD_SWITCH_OFF) begin
          o_prdata <= 32'h00000000;
        end else if (i_paddr == `RSD_TGT_IN_OFF) begin
          o_prdata <= {23'h0, tgt_vld_reg, tgt_in_reg};
        end else if (i_paddr == `RSD_PAT_IN_OFF) begin
          o_prdata <= {23'h0, pat_vld_reg, pat_in_reg};
        end else if (i_paddr == `RSD_STATUS_OFF) begin
          o_prdata <= {26'h0, rem_sync, p_blank, t_blank, standby_reg, selftest_reg,
                       any_locked};
        end else if (i_paddr == `RSD_DISP_OFF) begin
          o_prdata <= {16'h0, o_pat_speed, o_tgt_speed};
        end else if (i_paddr == `RSD_PRINT_OFF) begin
          o_prdata <= {8'h0, o_print_rec};
        end else begin
          o_prdata <= 32'h00000000;
          o_pslverr <= rd_en | i_pwrite;
        end
      end
    end
  end
endmodule // rsd_top

// File: testbench/rsd_top_monitor.sv
`timescale 1ns/10ps
// Port-level checks of the display block
module rsd_monitor (
  input wire i_clk,
  input wire i_srst,
  input wire i_psel,
  input wire i_penable,
  input wire [11:0] i_paddr,
  input wire o_pready,
  input wire o_pslverr,
  input wire i_remote_present,
  input wire [7:0] o_tgt_speed,
  input wire o_tgt_blank,
  input wire [7:0] o_pat_speed,
  input wire o_locked,
  input wire [7:0] o_rem_tgt,
  input wire [7:0] o_rem_pat,
  input wire o_rem_blank,
  input wire o_print_stb,
  input wire [23:0] o_print_rec
);
  default clocking dcb @(posedge i_clk);
  endclocking
  default disable iff (i_srst);
  // Bus answers one cycle after setup, for one cycle
  ready_in_access_a: assert property (i_psel && !i_penable |=> o_pready)
    else $error("no ready after setup");
  ready_single_a: assert property (o_pready |=> !o_pready)
    else $error("ready held too long");
  error_unmapped_a: assert property (o_pslverr |-> o_pready && $past(i_paddr) > 12'h018)
    else $error("error on mapped address");
  // Display holding and blanking
  lock_holds_a: assert property (
    o_locked [*2] ##1 o_locked |-> $stable(o_tgt_speed) && $stable(o_pat_speed))
    else $error("locked reading changed");
  blank_lock_a: assert property (o_locked && o_tgt_blank |=> o_tgt_blank || !o_locked)
    else $error("blank lock recalled a reading");
  // Remote unit and printer
  remote_mirror_a: assert property (
    !o_rem_blank |-> o_rem_tgt == $past(o_tgt_speed) && o_rem_pat == $past(o_pat_speed))
    else $error("remote differs from main display");
  replug_clear_a: assert property ($rose(i_remote_present) |-> o_rem_blank ##1 o_rem_blank
    ##1 o_rem_blank ##1 o_rem_blank)
    else $error("remote not cleared on reconnect");
  print_record_a: assert property (
    o_print_stb && o_locked |-> o_print_rec[15:0] == {o_tgt_speed, o_pat_speed})
    else $error("print record differs from lock");
  cover property ($rose(o_locked));
  cover property (o_print_stb && o_locked);
  cover property (o_pslverr);
endmodule // rsd_monitor

// File: testbench/rsd_remote_model.sv
`timescale 1ns/10ps
// Remote display and printer attached to the unit
module rsd_remote_model (
  input wire i_clk,
  input wire i_print_stb,
  input wire [23:0] i_print_rec,
  output reg o_present
);
  reg [23:0] last_rec = 24'h000000;
  initial begin
    o_present = 1'b1;
  end
  // Printer keeps the last record sent
  always @(posedge i_clk) begin
    if (i_print_stb) begin
      last_rec <= i_print_rec;
    end
  end
  // Unplug for a few cycles, then plug back in
  task replug;
    begin
      @(posedge i_clk);
      o_present <= 1'b0;
      repeat (6) @(posedge i_clk);
      o_present <= 1'b1;
    end
  endtask
endmodule // rsd_remote_model

// File: testbench/radar_speed_display_lock_clear_test.sv
`timescale 1ns/10ps
`include "rsd_defs.vh"
// Bench for the display lock and clear block
module radar_speed_display_lock_clear_test;
  reg clk, srst, psel, penable, pwrite, rerr;
  reg [11:0] paddr;
  reg [31:0] pwdata, rdat;
  wire [31:0] prdata;
  wire pready, pslverr, present, tblank, pblank, locked, rblank, pstb;
  wire [7:0] tgt, pat, rtgt, rpat;
  wire [23:0] prec;
  integer err_total = 0;
  integer checked = 0;
  integer cyc = 0;
  integer i;
  rsd_top u_dut (
    .i_clk(clk), .i_srst(srst), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_remote_present(present), .o_tgt_speed(tgt),
    .o_tgt_blank(tblank), .o_pat_speed(pat), .o_pat_blank(pblank), .o_locked(locked),
    .o_rem_tgt(rtgt), .o_rem_pat(rpat), .o_rem_blank(rblank), .o_print_stb(pstb),
    .o_print_rec(prec));
  rsd_remote_model u_rem (.i_clk(clk), .i_print_stb(pstb), .i_print_rec(prec),
    .o_present(present));
  // Clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Verdict and end of run
  task close_out;
    begin
      if (err_total == 0 && checked > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  // Compare and count
  task chk(input [31:0] got, input [31:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("FAIL %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // One APB transfer; data and error taken at the ready edge
  task xfer(input w, input [11:0] a, input [31:0] d);
    begin
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // Ready is sampled at each rising edge; the wait ends at the first edge that sees it high
      @(posedge clk);
      while (pready !== 1'b1)
        @(posedge clk);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  // Press one switch
  task sw(input integer b);
    xfer(1'b1, `RSD_SWITCH_OFF, 32'h1 << b);
  endtask
  // Let a write reach the displays
  task settle;
    repeat (3) @(posedge clk);
  endtask
  // Hang guard
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      err_total = err_total + 1;
      close_out;
    end
  end
  initial begin
    srst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    settle;
    xfer(1'b0, `RSD_STATUS_OFF, 32'h0);
    chk(rdat, 32'h0000003c);
    xfer(1'b0, `RSD_CTRL_OFF, 32'h0);
    chk(rdat, 32'h00000006);
    xfer(1'b0, 12'h01c, 32'h0);
    chk(rerr, 1'b1);
    // Target present when leaving standby, never locked by itself
    xfer(1'b1, `RSD_TGT_IN_OFF, 32'h114);
    sw(`RSD_SW_ON);
    settle;
    chk({locked, tblank, tgt}, 10'h014);
    // Moving mode, lock, then change and lose both signals
    xfer(1'b1, `RSD_CTRL_OFF, 32'h7);
    xfer(1'b1, `RSD_PAT_IN_OFF, 32'h137);
    xfer(1'b1, `RSD_TGT_IN_OFF, 32'h164);
    settle;
    chk({tblank, tgt, pat}, 17'h06437);
    sw(`RSD_SW_LOCK);
    xfer(1'b1, `RSD_TGT_IN_OFF, 32'h170);
    settle;
    xfer(1'b1, `RSD_TGT_IN_OFF, 32'h0);
    xfer(1'b1, `RSD_PAT_IN_OFF, 32'h0);
    settle;
    chk({locked, tblank, pblank, tgt, pat}, 19'h46437);
    sw(`RSD_SW_PRINT);
    settle;
    chk(u_rem.last_rec, 24'hc06437);
    chk({rtgt, rpat}, 16'h6437);
    // Standby keeps the lock, on clears it
    sw(`RSD_SW_STANDBY);
    settle;
    chk({locked, tgt}, 9'h164);
    sw(`RSD_SW_ON);
    settle;
    chk({locked, tblank, pblank}, 3'h3);
    // Lost target blanks; lock on a blank display stays blank
    xfer(1'b1, `RSD_TGT_IN_OFF, 32'h130);
    settle;
    xfer(1'b1, `RSD_TGT_IN_OFF, 32'h030);
    settle;
    chk(tblank, 1'b1);
    sw(`RSD_SW_LOCK);
    settle;
    chk(tblank, 1'b1);
    sw(`RSD_SW_ON);
    // Self-check value, lock ignored, cleared at the end
    sw(`RSD_SW_TEST);
    settle;
    chk({tblank, tgt}, 9'h088);
    sw(`RSD_SW_LOCK);
    sw(`RSD_SW_TEST_END);
    settle;
    chk({locked, tblank}, 2'h1);
    // Closing speed 210 mph suppressed, 209 mph shown
    xfer(1'b1, `RSD_PAT_IN_OFF, 32'h137);
    xfer(1'b1, `RSD_TGT_IN_OFF, 32'h19b);
    settle;
    chk(tblank, 1'b1);
    xfer(1'b1, `RSD_TGT_IN_OFF, 32'h19a);
    settle;
    chk({tblank, tgt}, 9'h09a);
    // Patrol ramps in 3 mph steps
    for (i = 0; i < 6; i = i + 1) begin
      xfer(1'b1, `RSD_PAT_IN_OFF, 32'h114 + 3 * i);
      settle;
      chk(pat, 8'h14 + 3 * i);
    end
    for (i = 0; i < 6; i = i + 1) begin
      xfer(1'b1, `RSD_PAT_IN_OFF, 32'h137 - 3 * i);
      settle;
      chk(pat, 8'h37 - 3 * i);
    end
    // Remote cleared on reconnect, then mirrors again
    // Fourth edge after plug-in: synchroniser high, display still cleared
    u_rem.replug;
    repeat (4) @(posedge clk);
    chk(rblank, 1'b1);
    repeat (2) @(posedge clk);
    chk({rblank, rtgt}, 9'h09a);
    chk(rpat, 8'h28);
    close_out;
  end
endmodule // radar_speed_display_lock_clear_test
bind rsd_top rsd_monitor u_mon (
  .i_clk(i_clk), .i_srst(i_srst), .i_psel(i_psel), .i_penable(i_penable),
  .i_paddr(i_paddr), .o_pready(o_pready), .o_pslverr(o_pslverr),
  .i_remote_present(i_remote_present), .o_tgt_speed(o_tgt_speed),
  .o_tgt_blank(o_tgt_blank), .o_pat_speed(o_pat_speed), .o_locked(o_locked),
  .o_rem_tgt(o_rem_tgt), .o_rem_pat(o_rem_pat), .o_rem_blank(o_rem_blank),
  .o_print_stb(o_print_stb), .o_print_rec(o_print_rec));
